// *** rtl/btscu_core.sv ***
// btscu_core: execution of bit-test skips and subroutine calls
`timescale 1ns/10ps
module btscu_core #(
   parameter int STACK_DEPTH = 8
) (
   input  wire logic                              clk,
   input  wire logic                              arst_n,
   input  wire btscu_pkg::btscu_op_t              op,
   input  wire logic                              op_valid,
   input  wire logic [btscu_pkg::FADDR_W-1:0]     file_addr,
   input  wire logic [btscu_pkg::BITSEL_W-1:0]    bit_sel,
   input  wire logic [btscu_pkg::DATA_W-1:0]      call_addr,
   input  wire logic [btscu_pkg::DATA_W-1:0]      file_rdata,
   input  wire logic [btscu_pkg::DATA_W-1:0]      accumulator,
   input  wire logic [btscu_pkg::DATA_W-1:0]      program_counter_high_buffer,
   input  wire logic [btscu_pkg::DATA_W-1:0]      table_high_pointer,
   output logic      [btscu_pkg::FADDR_W-1:0]     file_raddr,
   output logic      [btscu_pkg::PC_W-1:0]        pc,
   output logic                                   fetch_squash,
   output logic                                   busy,
   output logic      [btscu_pkg::SP_W-1:0]        stack_ptr,
   output logic      [btscu_pkg::PC_W-1:0]        stack_top
);
   localparam int PW = btscu_pkg::PC_W;

   typedef enum logic [1:0] {BTSCU_EXEC, BTSCU_SKIP, BTSCU_CALL2} btscu_state_t;

   // ------------------------------------------------------------
   // parameter checks
   // ------------------------------------------------------------
   // pointer width comes from the package, so the depth must fill it
   if (STACK_DEPTH != (1 << btscu_pkg::SP_W)) begin : g_bad_depth
      $error("btscu_core: STACK_DEPTH must equal 2**SP_W");
   end
   // call targets splice exactly two high bits above a byte
   if (PW != btscu_pkg::DATA_W + 2) begin : g_bad_pc_w
      $error("btscu_core: PC_W must be DATA_W plus two");
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // low two bits of a high register above an 8-bit address
   function automatic logic [PW-1:0] btscu_call_target(
      input logic [btscu_pkg::DATA_W-1:0] hi,
      input logic [btscu_pkg::DATA_W-1:0] lo
   );
      return {hi[PW-btscu_pkg::DATA_W-1:0], lo};
   endfunction : btscu_call_target

   btscu_state_t                    state_r;
   logic [PW-1:0]                   pc_r;
   logic                            squash_r;
   logic                            busy_r;
   logic [btscu_pkg::FADDR_W-1:0]   raddr_r;
   logic [btscu_pkg::SP_W-1:0]      sp_w;
   logic [PW-1:0]                   top_w;
   logic [btscu_pkg::SP_W-1:0]      sp_r;
   logic [PW-1:0]                   top_r;
   logic                            tbit;
   logic                            take_skip;
   logic                            is_call;
   logic                            push;
   logic [PW-1:0]                   target;
   logic [PW-1:0]                   ret_addr;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   // bit selected from file data
   assign tbit = file_rdata[bit_sel];

   always_comb begin
      take_skip = 1'b0;
      is_call   = 1'b0;
      target    = pc_r + 1'b1;
      if (op_valid && state_r == BTSCU_EXEC) begin
         unique case (op)
            btscu_pkg::BTSCU_OP_TEST_BIT_SKIP_IF_CLEAR: take_skip = ~tbit;
            btscu_pkg::BTSCU_OP_TEST_BIT_SKIP_IF_SET:   take_skip = tbit;
            btscu_pkg::BTSCU_OP_CALL: begin
               is_call = 1'b1;
               target  = btscu_call_target(program_counter_high_buffer, call_addr);
            end
            btscu_pkg::BTSCU_OP_CALL_VIA_ACCUMULATOR: begin
               is_call = 1'b1;
               target  = btscu_call_target(table_high_pointer, accumulator);
            end
            btscu_pkg::BTSCU_OP_NONE: ;
            // undefined op codes behave as no operation
            default: ;
         endcase
      end
   end

   // push return address once per call
   assign push = is_call;
   // return address is the word after the call
   assign ret_addr = pc_r + 1'b1;

   btscu_stack #(
      .DEPTH (STACK_DEPTH),
      .AW    (btscu_pkg::SP_W),
      .DW    (PW)
   ) u_stack (
      .clk       (clk),
      .arst_n    (arst_n),
      .push      (push),
      .push_data (ret_addr),
      .sp        (sp_w),
      .top       (top_w)
   );

   // ------------------------------------------------------------
   // sequencing
   // ------------------------------------------------------------
   // extra cycle for taken skip and for calls
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= BTSCU_EXEC;
      end else begin
         unique case (state_r)
            BTSCU_EXEC: begin
               if (take_skip) begin
                  state_r <= BTSCU_SKIP;
               end else if (is_call) begin
                  state_r <= BTSCU_CALL2;
               end
            end
            // one slot spent on the no-operation
            BTSCU_SKIP: begin
               state_r <= BTSCU_EXEC;
            end
            BTSCU_CALL2: begin
               state_r <= BTSCU_EXEC;
            end
         endcase
      end
   end

   // pc steps through the discarded slot; calls load target
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pc_r <= btscu_pkg::PC_RST;
      end else begin
         unique case (state_r)
            BTSCU_EXEC: begin
               pc_r <= target;
            end
            BTSCU_SKIP: begin
               pc_r <= pc_r + 1'b1;
            end
            // no fetch stall model: the call target simply waits a cycle
            BTSCU_CALL2: begin
               pc_r <= pc_r;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         squash_r <= 1'b0;
      end else begin
         squash_r <= take_skip | is_call;
      end
   end

   // busy flags the second cycle, in which state_r refuses a new op
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= take_skip | is_call;
      end
   end

   // ------------------------------------------------------------
   // registered echoes
   // ------------------------------------------------------------
   // every output leaves a flip-flop, so the echoes lag one cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         raddr_r <= '0;
      end else begin
         raddr_r <= file_addr;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sp_r <= btscu_pkg::SP_RST;
      end else begin
         sp_r <= sp_w;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         top_r <= '0;
      end else begin
         top_r <= top_w;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------

   assign pc           = pc_r;
   assign fetch_squash = squash_r;
   assign busy         = busy_r;
   assign file_raddr   = raddr_r;
   assign stack_ptr    = sp_r;
   assign stack_top    = top_r;
endmodule : btscu_core

// *** rtl/btscu_stack.sv ***
// btscu_stack: return address stack in flip-flops
`timescale 1ns/10ps
module btscu_stack #(
   parameter int DEPTH = 8,
   parameter int AW    = 3,
   parameter int DW    = 10
) (
   input  wire logic          clk,
   input  wire logic          arst_n,
   input  wire logic          push,
   input  wire logic [DW-1:0] push_data,
   output logic      [AW-1:0] sp,
   output logic      [DW-1:0] top
);
   logic [DW-1:0] mem_r [DEPTH];
   logic [AW-1:0] sp_r;

   // wrap on overflow relies on the pointer covering every entry
   if (DEPTH != (1 << AW)) begin : g_bad_depth
      $error("btscu_stack: DEPTH must equal 2**AW");
   end

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_ent
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               mem_r[g] <= '0;
            end else if (push && (sp_r == AW'(g))) begin
               mem_r[g] <= push_data;
            end
         end
      end
   endgenerate

   // pointer up after write; wraps on overflow
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sp_r <= AW'(btscu_pkg::SP_RST);
      end else if (push) begin
         sp_r <= sp_r + 1'b1;
      end
   end

   assign sp  = sp_r;
   assign top = mem_r[sp_r - 1'b1];
endmodule : btscu_stack

// *** shared/btscu_pkg.sv ***
// btscu_pkg: constants and types shared by the bit-test/skip/call unit
package btscu_pkg;
   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int PC_W      = 10;
   localparam int FADDR_W   = 6;
   localparam int DATA_W    = 8;
   localparam int BITSEL_W  = 3;
   localparam int STACK_D   = 8;
   localparam int SP_W      = 3;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [PC_W-1:0] PC_RST = 10'h000;
   localparam logic [SP_W-1:0] SP_RST = 3'h0;
   // ------------------------------------------------------------
   // operations presented by the decoder
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      BTSCU_OP_NONE,
      BTSCU_OP_TEST_BIT_SKIP_IF_CLEAR,
      BTSCU_OP_TEST_BIT_SKIP_IF_SET,
      BTSCU_OP_CALL,
      BTSCU_OP_CALL_VIA_ACCUMULATOR
   } btscu_op_t;
endpackage : btscu_pkg

// *** tb/btscu_core_assertions.sv ***
// port checks of skip and call timing
`timescale 1ns/10ps
module btscu_chk (
   input wire logic                 clk,
   input wire logic                 arst_n,
   input wire btscu_pkg::btscu_op_t op,
   input wire logic                 op_valid,
   input wire logic [2:0]           bit_sel,
   input wire logic [7:0]           file_rdata,
   input wire logic [7:0]           call_addr,
   input wire logic [7:0]           accumulator,
   input wire logic [7:0]           program_counter_high_buffer,
   input wire logic [7:0]           table_high_pointer,
   input wire logic [9:0]           pc,
   input wire logic                 fetch_squash,
   input wire logic                 busy,
   input wire logic [2:0]           stack_ptr,
   input wire logic [9:0]           stack_top
);
   logic t, b, s, c;
   assign t = op_valid && !busy;
   assign b = file_rdata[bit_sel];
   assign s = t && (op == 3'h1 && !b || op == 3'h2 && b);
   assign c = t && (op == 3'h3 || op == 3'h4);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_skip_taken: assert property (s |=> busy && fetch_squash)
      else $error("skip not taken");
   a_no_skip: assert property (t && (op == 3'h1 || op == 3'h2) && !s |=>
      !busy && pc == $past(pc) + 10'h001) else $error("bit test without skip wrong");
   a_skip_resume: assert property (s |=> ##1 !busy && pc == $past(pc, 2) + 10'h002)
      else $error("skip did not resume two words on");
   a_squash_one: assert property (fetch_squash |=> !fetch_squash)
      else $error("squash held too long");
   a_call_target: assert property (t && op == 3'h3 |=>
      pc == {$past(program_counter_high_buffer[1:0]), $past(call_addr)}) else $error("call pc");
   a_acc_target: assert property (t && op == 3'h4 |=>
      pc == {$past(table_high_pointer[1:0]), $past(accumulator)}) else $error("acc call pc");
   a_call_cycles: assert property (c |=> busy ##1 !busy && $stable(pc))
      else $error("call not two cycles");
   a_call_squash: assert property (c |=> fetch_squash)
      else $error("call slot not squashed");
   // pointer and top outputs lag the push by two cycles
   a_stack_push: assert property (c |-> ##2 stack_ptr == $past(stack_ptr, 2) + 3'h1)
      else $error("stack pointer not advanced");
   a_return_addr: assert property (c |-> ##2 stack_top == $past(pc, 2) + 10'h001)
      else $error("return address wrong");
endmodule : btscu_chk
bind btscu_core btscu_chk i_btscu_chk (.clk(clk), .arst_n(arst_n), .op(op),
   .op_valid(op_valid), .bit_sel(bit_sel), .file_rdata(file_rdata), .call_addr(call_addr),
   .accumulator(accumulator), .program_counter_high_buffer(program_counter_high_buffer),
   .table_high_pointer(table_high_pointer), .pc(pc), .fetch_squash(fetch_squash),
   .busy(busy), .stack_ptr(stack_ptr), .stack_top(stack_top));

// *** tb/btscu_core_tb_top.sv ***
// self-checking bench of the skip and call unit
`timescale 1ns/10ps
module btscu_core_tb_top;
   logic       clk = 1'b0;
   logic       arst_n = 1'b0;
   logic       op_valid = 1'b0;
   logic [2:0] o = 3'h0;
   logic [5:0] fa = 6'h00;
   logic [2:0] bs = 3'h0;
   logic [7:0] rd = 8'h00, ca = 8'h00, acc = 8'h00, hb = 8'h00, tp = 8'h00;
   logic [9:0] pc, top, e_pc, ret;
   logic [2:0] sp, e_sp;
   logic       sq, bz;
   logic [5:0] ra;
   int         n_fail = 0, n_tests = 0, cyc = 0;
   always #2.5 clk = ~clk;
   btscu_core i_btscu_core (.clk(clk), .arst_n(arst_n), .op(btscu_pkg::btscu_op_t'(o)),
      .op_valid(op_valid), .file_addr(fa), .bit_sel(bs), .call_addr(ca), .file_rdata(rd),
      .accumulator(acc), .program_counter_high_buffer(hb), .table_high_pointer(tp),
      .file_raddr(ra), .pc(pc), .fetch_squash(sq), .busy(bz), .stack_ptr(sp), .stack_top(top));
   task automatic chk(string nm, logic [9:0] ex, logic [9:0] got);
      n_tests++;
      if (got !== ex) begin
         n_fail++;
         $display("FAIL %s exp %h got %h", nm, ex, got);
      end
   endtask : chk
   // expected skip decision of a bit test
   function automatic logic f_skip(logic [2:0] op_i, logic [7:0] r, logic [2:0] b);
      return (op_i == 3'h1 && !r[b]) || (op_i == 3'h2 && r[b]);
   endfunction : f_skip
   // expected pc after the executing cycle
   function automatic logic [9:0] f_next_pc(logic [2:0] op_i, logic [9:0] p, logic [7:0] v,
      logic [7:0] a, logic [7:0] h, logic [7:0] t);
      if (op_i == 3'h3) return {h[1:0], v};
      if (op_i == 3'h4) return {t[1:0], a};
      return p + 10'h001;
   endfunction : f_next_pc
   task automatic end_of_test();
      if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         end_of_test();
      end
   end
   task automatic run(logic [2:0] op_i, logic [7:0] r, logic [2:0] b);
      logic       k;
      logic [7:0] v, a, h, t;
      v = 8'($urandom);
      a = 8'($urandom);
      h = 8'($urandom);
      t = 8'($urandom);
      k = f_skip(op_i, r, b);
      @(posedge clk);
      // the idle slot before each op also steps pc
      e_pc = e_pc + 10'h001;
      ret = e_pc + 10'h001;
      o <= op_i;
      op_valid <= 1'b1;
      rd <= r;
      bs <= b;
      fa <= 6'($urandom);
      ca <= v;
      acc <= a;
      hb <= h;
      tp <= t;
      @(posedge clk);
      // held high through busy so a refused repeat would show
      op_valid <= k || op_i > 3'h2;
      e_pc = f_next_pc(op_i, e_pc, v, a, h, t);
      #1 chk("pc", e_pc, pc);
      chk("busy", 10'(k || op_i > 3'h2), 10'(bz));
      chk("squash", 10'(k || op_i > 3'h2), 10'(sq));
      chk("raddr", 10'(fa), 10'(ra));
      if (k || op_i > 3'h2) begin
         @(posedge clk);
         op_valid <= 1'b0;
         if (k) e_pc = e_pc + 10'h001;
         if (op_i > 3'h2) e_sp = e_sp + 3'h1;
         #1 chk("resume", e_pc, pc);
         chk("sp", 10'(e_sp), 10'(sp));
         if (op_i > 3'h2) chk("ret", ret, top);
      end
   endtask : run
   initial begin
      void'($urandom(32'hEEDF44E9));
      e_pc = 10'h000;
      e_sp = 3'h0;
      repeat (4) @(posedge clk);
      chk("rst pc", btscu_pkg::PC_RST, pc);
      arst_n <= 1'b1;
      run(3'h1, 8'h7F, 3'h7);
      run(3'h2, 8'h80, 3'h7);
      run(3'h1, 8'h01, 3'h0);
      run(3'h4, 8'h00, 3'h0);
      run(3'h3, 8'hFF, 3'h0);
      run(3'h0, 8'hFF, 3'h3);
      repeat (80) run(3'($urandom_range(4, 1)), 8'($urandom), 3'($urandom));
      end_of_test();
   end
endmodule : btscu_core_tb_top
